/* File: design/bsq_pkg.sv */
package bsq_pkg;
  // Timebase
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned SEC_S = 1;
  localparam int unsigned SEC_CYC = CLK_HZ * SEC_S;
  // Sequence times in seconds
  localparam logic [7:0] PURGE_S = 8'h1E;
  localparam logic [7:0] SW_WAIT_S = 8'h0A;
  localparam logic [7:0] FLAME_WAIT_S = 8'h07;
  localparam logic [7:0] IGN_OFF_S = 8'h01;
  localparam logic [7:0] PROVE_S = 8'h02;
  localparam logic [7:0] CLOCK_S = 8'h05;
  // Air/fuel valve positions in percent
  localparam logic [6:0] POS_FULL = 7'h64;
  localparam logic [6:0] POS_LOW = 7'h1E;
  localparam logic [6:0] POS_START = 7'h19;
  localparam logic [6:0] POS_STOP = 7'h10;
  localparam logic [6:0] POS_CLOSED = 7'h00;
  // Register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_DEMAND = 8'h04;
  localparam logic [7:0] A_STATUS = 8'h08;
  localparam logic [7:0] A_SECS = 8'h0C;
  localparam int unsigned CTRL_CLR_BIT = 0;
  localparam int unsigned STAT_CODE_LSB = 16;
  // Fault codes
  localparam logic [3:0] F_NONE = 4'h0;
  localparam logic [3:0] F_POC = 4'h1;
  localparam logic [3:0] F_WATER = 4'h2;
  localparam logic [3:0] F_TEMP = 4'h3;
  localparam logic [3:0] F_HI_GAS = 4'h4;
  localparam logic [3:0] F_LO_GAS = 4'h5;
  localparam logic [3:0] F_BLOWER = 4'h6;
  localparam logic [3:0] F_DS_GAS = 4'h7;
  localparam logic [3:0] F_PURGE_SW = 4'h8;
  localparam logic [3:0] F_IGN_SW = 4'h9;
  localparam logic [3:0] F_NO_FLAME = 4'hA;
  localparam logic [3:0] F_FLAME_LOST = 4'hB;
  // Display codes
  localparam logic [2:0] D_OFF = 3'h0;
  localparam logic [2:0] D_STBY = 3'h1;
  localparam logic [2:0] D_PURGING = 3'h2;
  localparam logic [2:0] D_IGNITION = 3'h3;
  localparam logic [2:0] D_PROVEN = 3'h4;
  localparam logic [2:0] D_CLOCK = 3'h5;
  localparam logic [2:0] D_FAULT = 3'h6;

  typedef enum logic [8:0] {
    ST_OFF = 9'h001,
    ST_STBY = 9'h002,
    ST_POC = 9'h004,
    ST_PWAIT = 9'h008,
    ST_PURGE = 9'h010,
    ST_IGN = 9'h020,
    ST_FLAME = 9'h040,
    ST_FIRE = 9'h080,
    ST_FAULT = 9'h100
  } bsq_state_e;

  // Field switches, 1 = closed; flame 1 = detected
  typedef struct packed {
    logic closure_proof_switch;
    logic low_water;
    logic high_temp;
    logic high_gas;
    logic low_gas;
    logic blower_proof;
    logic ds_low_gas;
    logic purge_pos;
    logic ign_pos;
    logic flame;
  } bsq_sw_s;

  typedef struct packed {
    logic ready;
    logic demand;
    logic blower;
    logic igniter;
    logic gas_shutoff_valve;
    logic fault;
    logic [6:0] valve_pos;
    logic [6:0] bar;
    logic [2:0] disp;
    logic [7:0] disp_val;
    logic [3:0] fault_code;
  } bsq_out_s;
endpackage

/* File: design/bsq_sequencer.sv */
`timescale 1ns/1ps
// Function
// - On switch-on, check closure proof, water, temperature, gas and blower.
// - Downstream low gas switch is not part of the pre-purge check.
// - All interlocks closed lights ready and enters standby.
// - Any open interlock or missing condition reports a code and faults.
// - Demand in standby lights the demand indicator.
// - Closure proof switch must read closed before purge starts.
// - Purge start energizes the blower relay.
// - Purge commands valve full open, expects purge switch, shows 100%.
// - Blower proof closed shows purging with elapsed seconds.
// - Ignition commands low fire position and expects ignition switch.
// - Igniter relay is on during ignition.
// - Gas shutoff valve is energized during ignition.
// - Flame must appear within 7 seconds or the start faults.
// - Igniter drops one second after flame is first seen.
// - Two seconds continuous flame declares flame proven with strength.
// - Five seconds after proving, show date and time instead.
// - While firing, valve follows demand and bar graph shows it.
// - Demand satisfied closes gas valve, blower, air valve; back to standby.
// - Start at demand 25 percent, stop at 16 percent.
module bsq_sequencer #(
  parameter int unsigned SEC_CYCLES = bsq_pkg::SEC_CYC,
  parameter logic [7:0] PURGE_SECONDS = bsq_pkg::PURGE_S
) (
  // Clock and reset
  input logic clk_i,
  input logic nrst_i,
  // Field side
  input logic on_i,
  input bsq_pkg::bsq_sw_s sw_i,
  input logic [7:0] flame_pct_i,
  output bsq_pkg::bsq_out_s out_o,
  // AHB-Lite slave
  input logic hsel_i,
  input logic [7:0] haddr_i,
  input logic [1:0] htrans_i,
  input logic hwrite_i,
  input logic [2:0] hsize_i,
  input logic [31:0] hwdata_i,
  input logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o
);
  import bsq_pkg::*;
  bsq_state_e state_reg, state_next;
  logic [3:0] code_reg, code_next;
  logic [24:0] cyc_reg;
  logic [7:0] sec_reg;
  logic [6:0] dem_reg;
  logic clr_reg;
  logic wr_ph_reg;
  logic [7:0] addr_ph_reg;
  bsq_out_s out_reg;
  logic [3:0] pre_c, run_c;
  logic active_c, fired_c;
  ////////////////////////////////////////////////////////////////////////
  // First open interlock; pre adds the switches only checked before purge
  function automatic logic [3:0] open_code(input bsq_sw_s s,
                                           input logic pre);
    open_code = F_NONE;
    if (pre && !s.closure_proof_switch)
      open_code = F_POC;
    else if (!s.low_water)
      open_code = F_WATER;
    else if (!s.high_temp)
      open_code = F_TEMP;
    else if (!s.high_gas)
      open_code = F_HI_GAS;
    else if (!s.low_gas)
      open_code = F_LO_GAS;
    else if (pre && !s.blower_proof)
      open_code = F_BLOWER;
  endfunction
  assign pre_c = open_code(sw_i, 1'b1);
  assign active_c = !(state_reg inside {ST_OFF, ST_STBY, ST_FAULT});
  assign fired_c = state_reg inside {ST_IGN, ST_FLAME, ST_FIRE};
  // Downstream switch only matters once gas is flowing
  assign run_c = (open_code(sw_i, 1'b0) == F_NONE && fired_c
                  && !sw_i.ds_low_gas) ? F_DS_GAS : open_code(sw_i, 1'b0);
  ////////////////////////////////////////////////////////////////////////
  // Sequence
  always_comb
  begin
    state_next = state_reg;
    code_next = code_reg;
    case (state_reg)
      ST_OFF, ST_STBY:
        if (!on_i)
          state_next = ST_OFF;
        else if (pre_c != F_NONE)
        begin
          state_next = ST_FAULT;
          code_next = pre_c;
        end
        else if (state_reg == ST_OFF)
          state_next = ST_STBY;
        else if (dem_reg >= POS_START)
          state_next = ST_POC;
      ST_POC:
        if (sw_i.closure_proof_switch)
          state_next = ST_PWAIT;
        else
        begin
          state_next = ST_FAULT;
          code_next = F_POC;
        end
      ST_PWAIT:
        if (sw_i.blower_proof && sw_i.purge_pos)
          state_next = ST_PURGE;
        else if (sec_reg >= SW_WAIT_S)
        begin
          state_next = ST_FAULT;
          code_next = sw_i.purge_pos ? F_BLOWER : F_PURGE_SW;
        end
      ST_PURGE:
        if (!(sw_i.blower_proof && sw_i.purge_pos))
        begin
          state_next = ST_FAULT;
          code_next = sw_i.purge_pos ? F_BLOWER : F_PURGE_SW;
        end
        else if (sec_reg >= PURGE_SECONDS)
          state_next = ST_IGN;
      ST_IGN:
        if (sw_i.flame)
          state_next = ST_FLAME;
        else if (sec_reg >= FLAME_WAIT_S)
        begin
          state_next = ST_FAULT;
          code_next = sw_i.ign_pos ? F_NO_FLAME : F_IGN_SW;
        end
      ST_FLAME, ST_FIRE:
        if (!sw_i.flame)
        begin
          state_next = ST_FAULT;
          code_next = F_FLAME_LOST;
        end
        else if (state_reg == ST_FLAME && sec_reg >= PROVE_S)
          state_next = ST_FIRE;
        else if (state_reg == ST_FIRE && dem_reg <= POS_STOP)
          state_next = ST_STBY;
      ST_FAULT:
        if (clr_reg)
        begin
          state_next = ST_OFF;
          code_next = F_NONE;
        end
      default:
        state_next = ST_OFF;
    endcase
    // Safety limits outrank every step of the sequence
    if (active_c && !on_i)
      state_next = ST_OFF;
    if (active_c && run_c != F_NONE)
    begin
      state_next = ST_FAULT;
      code_next = run_c;
    end
  end
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_reg <= ST_OFF;
      code_reg <= F_NONE;
    end
    else
    begin
      state_reg <= state_next;
      code_reg <= code_next;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Seconds since entering the current state
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cyc_reg <= 25'h0000000;
      sec_reg <= 8'h00;
    end
    else if (state_next != state_reg)
    begin
      cyc_reg <= 25'h0000000;
      sec_reg <= 8'h00;
    end
    else if (cyc_reg == 25'(SEC_CYCLES - 1))
    begin
      cyc_reg <= 25'h0000000;
      if (sec_reg != 8'hFF)
        sec_reg <= sec_reg + 8'h01;
    end
    else
      cyc_reg <= cyc_reg + 25'h0000001;
  end
  ////////////////////////////////////////////////////////////////////////
  // Outputs, one cycle behind the state; bar graph two cycles behind
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      out_reg <= '0;
    else
    begin
      out_reg.ready <= on_i && state_reg != ST_FAULT
                       && state_reg != ST_OFF;
      out_reg.demand <= state_reg inside {ST_POC, ST_PWAIT, ST_PURGE,
                                          ST_IGN, ST_FLAME, ST_FIRE};
      out_reg.blower <= state_reg inside {ST_PWAIT, ST_PURGE, ST_IGN,
                                          ST_FLAME, ST_FIRE};
      out_reg.igniter <= state_reg == ST_IGN || (state_reg == ST_FLAME
                         && sec_reg < IGN_OFF_S);
      out_reg.gas_shutoff_valve <= fired_c;
      out_reg.fault <= state_reg == ST_FAULT;
      out_reg.fault_code <= code_reg;
      case (state_reg)
        ST_PWAIT, ST_PURGE:
          out_reg.valve_pos <= POS_FULL;
        ST_IGN, ST_FLAME:
          out_reg.valve_pos <= POS_LOW;
        ST_FIRE:
          out_reg.valve_pos <= dem_reg;
        default:
          out_reg.valve_pos <= POS_CLOSED;
      endcase
      out_reg.bar <= out_reg.valve_pos;
      out_reg.disp_val <= 8'h00;
      case (state_reg)
        ST_STBY, ST_POC, ST_PWAIT:
          out_reg.disp <= D_STBY;
        ST_PURGE:
        begin
          out_reg.disp <= D_PURGING;
          out_reg.disp_val <= sec_reg;
        end
        ST_IGN, ST_FLAME:
          out_reg.disp <= D_IGNITION;
        ST_FIRE:
          if (sec_reg >= CLOCK_S)
            out_reg.disp <= D_CLOCK;
          else
          begin
            out_reg.disp <= D_PROVEN;
            out_reg.disp_val <= flame_pct_i;
          end
        ST_FAULT:
          out_reg.disp <= D_FAULT;
        default:
          out_reg.disp <= D_OFF;
      endcase
    end
  end
  assign out_o = out_reg;
  ////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, always OKAY
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wr_ph_reg <= 1'b0;
      addr_ph_reg <= 8'h00;
      hrdata_o <= 32'h00000000;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
    else
    begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      if (hready_i)
      begin
        wr_ph_reg <= hsel_i && htrans_i[1] && hwrite_i;
        addr_ph_reg <= haddr_i;
        hrdata_o <= 32'h00000000;
        case (haddr_i)
          A_DEMAND:
            // Bypass a write still in its data phase
            hrdata_o[6:0] <= (wr_ph_reg && addr_ph_reg == A_DEMAND)
                             ? hwdata_i[6:0] : dem_reg;
          A_STATUS:
            hrdata_o <= {12'h000, code_reg, 7'h00, state_reg};
          A_SECS:
            hrdata_o[7:0] <= sec_reg;
          default:
            hrdata_o <= 32'h00000000;
        endcase
      end
    end
  end
  // Demanded position from the temperature controller software
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      dem_reg <= POS_CLOSED;
      clr_reg <= 1'b0;
    end
    else
    begin
      clr_reg <= wr_ph_reg && addr_ph_reg == A_CTRL
                 && hwdata_i[CTRL_CLR_BIT];
      if (wr_ph_reg && addr_ph_reg == A_DEMAND)
        dem_reg <= hwdata_i[6:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  pre_fault_a: assert property (state_reg == ST_OFF && on_i
    && pre_c != F_NONE |=> state_reg == ST_FAULT && code_reg != F_NONE)
    else $error("open interlock not faulted");
  ds_excl_a: assert property (state_reg == ST_OFF && on_i
    && pre_c == F_NONE && !sw_i.ds_low_gas |=> state_reg == ST_STBY)
    else $error("downstream switch blocked standby");
  ready_lit_a: assert property (state_reg == ST_STBY && on_i
    |=> out_o.ready) else $error("ready not lit");
  fault_out_a: assert property (state_reg == ST_FAULT
    |=> out_o.fault && out_o.fault_code == $past(code_reg))
    else $error("fault not shown");
  demand_lit_a: assert property (state_reg == ST_POC
    |=> out_o.demand) else $error("demand not lit");
  poc_chk_a: assert property (state_reg == ST_POC && !sw_i.closure_proof_switch
    |=> state_reg == ST_FAULT) else $error("closure proof ignored");
  purge_out_a: assert property (state_reg == ST_PURGE
    |=> out_o.blower ##1 out_o.bar == POS_FULL)
    else $error("purge outputs wrong");
  purge_full_a: assert property (state_reg == ST_PWAIT
    |=> out_o.valve_pos == POS_FULL) else $error("purge not full open");
  purge_disp_a: assert property (state_reg == ST_PURGE
    |=> out_o.disp == D_PURGING && out_o.disp_val == $past(sec_reg))
    else $error("purge display wrong");
  low_fire_a: assert property (state_reg == ST_IGN
    |=> out_o.valve_pos == POS_LOW) else $error("not low fire");
  spark_gas_a: assert property (state_reg == ST_IGN
    |=> out_o.igniter && out_o.gas_shutoff_valve)
    else $error("ignition outputs off");
  flame_wait_a: assert property (state_reg == ST_IGN && active_c
    && sec_reg >= FLAME_WAIT_S && !sw_i.flame |=> state_reg == ST_FAULT)
    else $error("flame wait not bounded");
  ign_drop_a: assert property (state_reg == ST_FLAME
    && sec_reg >= IGN_OFF_S |=> !out_o.igniter)
    else $error("igniter stayed on");
  proven_a: assert property ($rose(state_reg == ST_FIRE)
    |-> $past(state_reg == ST_FLAME && sec_reg >= PROVE_S))
    else $error("flame proven too early");
  clock_disp_a: assert property (state_reg == ST_FIRE
    && sec_reg >= CLOCK_S |=> out_o.disp == D_CLOCK)
    else $error("clock not shown");
  fire_bar_a: assert property (state_reg == ST_FIRE
    |=> out_o.valve_pos == $past(dem_reg) ##1 out_o.bar == $past(dem_reg, 2))
    else $error("valve not tracking demand");
  shut_a: assert property (state_reg == ST_FIRE ##1 state_reg == ST_STBY
    |=> !out_o.gas_shutoff_valve && !out_o.blower
        && out_o.valve_pos == POS_CLOSED) else $error("shutdown incomplete");
  start_lvl_a: assert property (state_reg == ST_STBY && on_i
    && pre_c == F_NONE && dem_reg >= POS_START |=> state_reg == ST_POC)
    else $error("start level missed");
  purge_len_a: assert property ($rose(state_reg == ST_IGN)
    |-> $past(state_reg == ST_PURGE && sec_reg >= PURGE_SECONDS))
    else $error("purge cut short");
  fire_c: cover property (state_reg == ST_FLAME ##1 state_reg == ST_FIRE);
  stop_c: cover property (state_reg == ST_FIRE ##1 state_reg == ST_STBY);
  nflame_c: cover property (state_reg == ST_IGN ##1 code_reg == F_NO_FLAME);
  clear_c: cover property (state_reg == ST_FAULT ##1 state_reg == ST_OFF);
endmodule

/* File: verification/bsq_field_model.sv */
`timescale 1ns/1ps
module bsq_field_model
  import bsq_pkg::*;
(
  // Clock and reset
  input logic clk_i,
  input logic nrst_i,
  // Sequencer outputs
  input bsq_pkg::bsq_out_s out_i,
  // Bench controls
  input logic [5:0] open_i,
  input logic ds_ok_i,
  input logic flame_ok_i,
  // Switch levels
  output bsq_pkg::bsq_sw_s sw_o
);
  logic purge_reg;
  logic ign_reg;
  logic flame_reg;

  ////////////////////////////////////////////////////////////////////////
  // End switches trail the actuator by a cycle, as a real valve does
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      purge_reg <= 1'b0;
      ign_reg <= 1'b0;
      flame_reg <= 1'b0;
    end
    else
    begin
      purge_reg <= out_i.valve_pos == 7'h64;
      ign_reg <= out_i.valve_pos >= 7'h19 && out_i.valve_pos <= 7'h23;
      // Flame needs gas and spark to light, then holds on gas alone
      flame_reg <= flame_ok_i && out_i.gas_shutoff_valve
                   && (out_i.igniter || flame_reg);
    end
  end

  always_comb
  begin
    sw_o.closure_proof_switch = !open_i[5];
    sw_o.low_water = !open_i[4];
    sw_o.high_temp = !open_i[3];
    sw_o.high_gas = !open_i[2];
    sw_o.low_gas = !open_i[1];
    sw_o.blower_proof = !open_i[0];
    sw_o.ds_low_gas = ds_ok_i;
    sw_o.purge_pos = purge_reg;
    sw_o.ign_pos = ign_reg;
    sw_o.flame = flame_reg;
  end
endmodule

/* File: verification/burner_start_sequencer_tb.sv */
`timescale 1ns/1ps
module burner_start_sequencer_tb;
  import bsq_pkg::*;
  // One second shrunk to 10 cycles to keep the run short
  localparam int SC = 10;
  localparam int PS = 2;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic on_i = 1'b0;
  logic [7:0] flame_pct = 8'h00;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic [5:0] open_sw = 6'h00;
  logic ds_ok = 1'b1;
  logic flame_ok = 1'b1;
  logic [31:0] rd;
  bsq_sw_s sw;
  bsq_out_s out;
  int err_total = 0;
  int n_tests = 0;
  int n;
  int ni;

  always #25 clk_i = ~clk_i;

  bsq_sequencer #(.SEC_CYCLES(SC), .PURGE_SECONDS(8'(PS))) u_dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .on_i(on_i), .sw_i(sw),
    .flame_pct_i(flame_pct), .out_o(out), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp));

  bsq_field_model u_field (
    .clk_i(clk_i), .nrst_i(nrst_i), .out_i(out), .open_i(open_sw),
    .ds_ok_i(ds_ok), .flame_ok_i(flame_ok), .sw_o(sw));

  ////////////////////////////////////////////////////////////////////////
  task results;
    $display("Comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task timeout(input string nm);
    err_total++;
    $display("Error %s expected done seen timeout", nm);
    results();
  endtask

  task automatic chk(input string nm, input logic [63:0] e,
                     input logic [63:0] g);
    n_tests++;
    if (g !== e)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rng(input string nm, input int lo, input int hi,
                     input int g);
    n_tests++;
    if (g < lo || g > hi)
    begin
      err_total++;
      $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask

  // Values are taken in the low phase before the edge that samples them
  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [31:0] wd, output logic [31:0] r);
    logic rdy;
    int k;
    @(posedge clk_i);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    for (int ph = 0; ph < 2; ph++)
    begin
      k = 0;
      rdy = 1'b0;
      while (rdy !== 1'b1)
      begin
        @(negedge clk_i);
        rdy = hready;
        r = hrdata;
        @(posedge clk_i);
        k++;
        if (k > 50)
          timeout("bus");
      end
      if (ph == 0)
      begin
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
      end
    end
  endtask

  task automatic wait_disp(input logic [2:0] d, input int mx,
                           output int k);
    k = 0;
    @(negedge clk_i);
    while (out.disp !== d)
    begin
      @(negedge clk_i);
      k++;
      if (k > mx)
        timeout("disp");
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  task t_reset;
    chk("out", 64'h0, 64'(out));
    xfer(A_STATUS, 1'b0, 32'h0, rd);
    chk("status", 64'h1, 64'(rd));
    xfer(8'h10, 1'b0, 32'h0, rd);
    chk("unmapped", 64'h0, 64'(rd));
    chk("hresp", 64'h0, 64'(hresp));
    $display("Test reset done");
  endtask

  task t_start;
    @(posedge clk_i);
    ds_ok <= 1'b0;
    on_i <= 1'b1;
    wait_disp(D_STBY, 20, n);
    chk("ready", 64'h1, 64'(out.ready));
    @(posedge clk_i);
    ds_ok <= 1'b1;
    xfer(A_DEMAND, 1'b1, 32'h18, rd);
    xfer(A_DEMAND, 1'b0, 32'h0, rd);
    chk("dem rb", 64'h18, 64'(rd));
    repeat (10) @(negedge clk_i);
    chk("no start", 64'(D_STBY), 64'(out.disp));
    chk("no dem", 64'h0, 64'(out.demand));
    $display("Test start done");
  endtask

  task t_fire;
    @(posedge clk_i);
    flame_pct <= 8'h5A;
    xfer(A_DEMAND, 1'b1, 32'h19, rd);
    n = 0;
    while (out.blower !== 1'b1)
    begin
      @(negedge clk_i);
      n++;
      if (n > 20)
        timeout("blower");
    end
    chk("demand", 64'h1, 64'(out.demand));
    chk("purge pos", 64'(POS_FULL), 64'(out.valve_pos));
    wait_disp(D_PURGING, 10 * SC, n);
    repeat (SC + 2) @(negedge clk_i);
    chk("elapsed", 64'h1, 64'(out.disp_val));
    wait_disp(D_IGNITION, 10 * SC, n);
    rng("purge len", PS * SC - 14, PS * SC - 9, n);
    chk("low fire", 64'h1E, 64'(out.valve_pos));
    chk("spark gas", 64'h3, 64'({out.igniter, out.gas_shutoff_valve}));
    n = 0;
    while (sw.flame !== 1'b1)
    begin
      @(negedge clk_i);
      n++;
      if (n > 20)
        timeout("flame");
    end
    n = 0;
    ni = 0;
    while (out.disp !== D_PROVEN)
    begin
      @(negedge clk_i);
      n++;
      if (out.igniter === 1'b1)
        ni = n;
      if (n > 5 * SC)
        timeout("proven");
    end
    rng("spark off", SC - 1, SC + 2, ni);
    rng("prove time", 2 * SC, 2 * SC + 3, n);
    chk("strength", 64'h5A, 64'(out.disp_val));
    wait_disp(D_CLOCK, 10 * SC, n);
    rng("clock time", 5 * SC - 2, 5 * SC + 2, n);
    xfer(A_DEMAND, 1'b1, 32'h50, rd);
    repeat (4) @(negedge clk_i);
    chk("fire pos", 64'h5050, 64'({1'b0, out.valve_pos, 1'b0, out.bar}));
    xfer(A_DEMAND, 1'b1, 32'h11, rd);
    repeat (4) @(negedge clk_i);
    chk("still fire", 64'(D_CLOCK), 64'(out.disp));
    xfer(A_DEMAND, 1'b1, 32'h10, rd);
    wait_disp(D_STBY, 20, n);
    chk("shut", 64'h0, 64'({out.blower, out.igniter,
        out.gas_shutoff_valve, out.valve_pos}));
    $display("Test fire done");
  endtask

  task t_noflame;
    @(posedge clk_i);
    flame_ok <= 1'b0;
    xfer(A_DEMAND, 1'b1, 32'h20, rd);
    wait_disp(D_IGNITION, 10 * SC, n);
    wait_disp(D_FAULT, 10 * SC, n);
    rng("flame wait", 7 * SC - 1, 7 * SC + 3, n);
    chk("code", 64'(F_NO_FLAME), 64'(out.fault_code));
    chk("gas off", 64'h0, 64'(out.gas_shutoff_valve));
    xfer(A_STATUS, 1'b0, 32'h0, rd);
    chk("stat", 64'h000A0100, 64'(rd));
    @(posedge clk_i);
    flame_ok <= 1'b1;
    xfer(A_DEMAND, 1'b1, 32'h0, rd);
    xfer(A_CTRL, 1'b1, 32'h1, rd);
    wait_disp(D_STBY, 20, n);
    $display("Test no flame done");
  endtask

  task t_interlock;
    for (int i = 0; i < 6; i++)
    begin
      @(posedge clk_i);
      open_sw <= 6'h20 >> i;
      wait_disp(D_FAULT, 20, n);
      chk("code", 64'(i + 1), 64'(out.fault_code));
      chk("rdy flt", 64'h1, 64'({out.ready, out.fault}));
      @(posedge clk_i);
      open_sw <= 6'h00;
      xfer(A_CTRL, 1'b1, 32'h1, rd);
      wait_disp(D_STBY, 20, n);
    end
    $display("Test interlock done");
  endtask

  // Flame loss while firing, then downstream gas switch open at ignition
  task t_loss;
    xfer(A_DEMAND, 1'b1, 32'h20, rd);
    wait_disp(D_PROVEN, 10 * SC, n);
    @(posedge clk_i);
    flame_ok <= 1'b0;
    wait_disp(D_FAULT, 20, n);
    chk("lost code", 64'(F_FLAME_LOST), 64'(out.fault_code));
    @(posedge clk_i);
    flame_ok <= 1'b1;
    ds_ok <= 1'b0;
    xfer(A_CTRL, 1'b1, 32'h1, rd);
    wait_disp(D_STBY, 20, n);
    wait_disp(D_FAULT, 10 * SC, n);
    chk("ds code", 64'(F_DS_GAS), 64'(out.fault_code));
    chk("ds gas", 64'h0, 64'(out.gas_shutoff_valve));
    @(posedge clk_i);
    ds_ok <= 1'b1;
    xfer(A_DEMAND, 1'b1, 32'h0, rd);
    xfer(A_CTRL, 1'b1, 32'h1, rd);
    wait_disp(D_STBY, 20, n);
    $display("Test loss done");
  endtask

  initial
  begin
    repeat (8) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(negedge clk_i);
    t_reset();
    t_start();
    t_fire();
    t_noflame();
    t_interlock();
    t_loss();
    results();
  end
endmodule
